// ===== hdl/adcc_pkg.sv
// adcc_pkg: widths, counts, reset values and state type of the converter
// control block.
// assumes: one 50 MHz clock; used by both design files.
package adcc_pkg;
  // clock rate and conversion timing
  localparam int ADCC_CLK_HZ = 50_000_000;
  localparam int ADCC_RES_BITS = 10;
  localparam int ADCC_CHAN_BITS = 4;
  localparam int ADCC_SAMPLE_CYCLES = 16;
  localparam int ADCC_STEP_CYCLES = 8;
  // result layout: upper 8 bits high, lowest 2 bits low
  localparam int ADCC_HIGH_LSB = 2;
  localparam int ADCC_LOW_WIDTH = 2;
  // saturated values
  localparam logic [9:0] ADCC_FULL_SCALE = 10'h3FF;
  localparam logic [9:0] ADCC_ZERO_SCALE = 10'h000;
  // reset values
  localparam logic [7:0] ADCC_RESULT_RST = 8'h00;
  localparam logic [3:0] ADCC_CHAN_RST = 4'h0;

  typedef enum logic [1:0] {
    ADCC_OFF,
    ADCC_SAMPLE,
    ADCC_CONVERT
  } adcc_state_t;
endpackage : adcc_pkg

// ===== hdl/adcc_sar_engine.sv
// adcc_sar_engine: successive approximation sequencer, one bit per step.
// assumes: the analog core compares the sampled input against trialCode
// and answers on compareHigh before the next step enable.
`timescale 1ns/1ps
`default_nettype none
module adcc_sar_engine
  import adcc_pkg::*;
#(
  parameter int RES_BITS = ADCC_RES_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic stepEn,
  input wire logic compareHigh,
  output logic [RES_BITS-1:0] trialCode,
  output logic busy,
  output logic done,
  output logic [RES_BITS-1:0] result
);
  logic [RES_BITS-1:0] trial_reg, trial_next;
  logic [RES_BITS-1:0] mask_reg, mask_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  // ===========================================================
  // bit decision
  // abort wins over start so a channel change never finishes old data
  always_comb begin
    trial_next = trial_reg;
    mask_next = mask_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (abort) begin
      busy_next = 1'b0;
      trial_next = '0;
      mask_next = '0;
    end else if (start) begin
      busy_next = 1'b1;
      mask_next = {1'b1, {(RES_BITS-1){1'b0}}};
      trial_next = {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (busy_reg && stepEn) begin
      // drop the trial bit when the input is below it
      if (!compareHigh) begin
        trial_next = trial_reg & ~mask_reg;
      end
      mask_next = mask_reg >> 1;
      trial_next = trial_next | (mask_reg >> 1);
      if (mask_reg[0]) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trial_reg <= '0;
      mask_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      trial_reg <= trial_next;
      mask_reg <= mask_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign trialCode = trial_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign result = trial_reg; // final code once done pulses
endmodule : adcc_sar_engine
`default_nettype wire

// ===== hdl/adcc_conversion_control.sv
// adcc_conversion_control: control of a 10-bit successive approximation
// converter with a 16-way input multiplexer and continuous conversion.
// assumes: control inputs come from a CPU-side register decoder as plain
// levels and one-cycle strobes, synchronous to clk; the analog core sits
// on the mux, sample-hold and compare pins.
//
// What this block does
// - each conversion yields a 10-bit value spread over two result bytes
// - input above upper reference gives all ones high, 3 low
// - input below lower reference gives zero in both bytes
// - four-bit channel field picks one of 16 multiplexed inputs
// - setting the on bit starts back-to-back conversions of the channel
// - each completion updates both result bytes and sets the done flag
// - reading the high byte clears the done flag; low byte read does not
// - channel write aborts conversion, clears flag, restarts on new channel
// - clearing the on bit stops conversions and powers the core down
`timescale 1ns/1ps
`default_nettype none
module adcc_conversion_control
  import adcc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = ADCC_SAMPLE_CYCLES,
  parameter int STEP_CYCLES = ADCC_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic converterOn,
  input wire logic [ADCC_CHAN_BITS-1:0] channelSelectField,
  input wire logic channelWrite,
  input wire logic resultHighRead,
  input wire logic resultLowRead,
  input wire logic compareHigh,
  input wire logic aboveRef,
  input wire logic belowRef,
  output logic [7:0] resultHigh,
  output logic [7:0] resultLow,
  output logic conversionDoneFlag,
  output logic [ADCC_CHAN_BITS-1:0] muxSelect,
  output logic analogEnable,
  output logic sampleHold,
  output logic [ADCC_RES_BITS-1:0] trialCode
);
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

  // split a 10-bit code into the two result bytes
  function automatic logic [15:0] pack_result(
    input logic [ADCC_RES_BITS-1:0] code
  );
    logic [15:0] packed_bytes;
    packed_bytes = {code[ADCC_RES_BITS-1:ADCC_HIGH_LSB], 6'h00,
      code[ADCC_LOW_WIDTH-1:0]};
    return packed_bytes;
  endfunction : pack_result

  adcc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] high_reg, high_next;
  logic [7:0] low_reg, low_next;
  logic done_reg, done_next;
  logic [ADCC_CHAN_BITS-1:0] chan_reg, chan_next;
  logic on_reg, on_next;
  logic hold_reg, hold_next;
  logic above_reg, above_next;
  logic below_reg, below_next;
  logic sarStart, sarAbort, stepEn;
  logic sarBusy, sarDone;
  logic [ADCC_RES_BITS-1:0] sarResult;
  logic [ADCC_RES_BITS-1:0] finalCode;
  logic [15:0] packedResult;

  // ===========================================================
  // saturation of the finished code
  always_comb begin
    if (above_reg) begin
      finalCode = ADCC_FULL_SCALE; // no overflow flag is raised
    end else if (below_reg) begin
      finalCode = ADCC_ZERO_SCALE;
    end else begin
      finalCode = sarResult;
    end
    packedResult = pack_result(finalCode);
  end

  // ===========================================================
  // sequencer: off, sample, convert, then sample again
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    chan_next = chan_reg;
    on_next = converterOn;
    hold_next = 1'b0;
    above_next = above_reg;
    below_next = below_reg;
    sarStart = 1'b0;
    sarAbort = 1'b0;
    stepEn = 1'b0;
    if (channelWrite) begin
      chan_next = channelSelectField;
    end
    unique case (state_reg)
      ADCC_OFF: begin
        cnt_next = '0;
        if (converterOn) begin
          // open the hold at once so the first sample is as long as the rest
          hold_next = 1'b1;
          state_next = ADCC_SAMPLE;
        end
      end
      ADCC_SAMPLE: begin
        hold_next = 1'b1;
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == SAMPLE_LAST) begin
          // range comparators are read as the hold closes
          above_next = aboveRef;
          below_next = belowRef;
          cnt_next = '0;
          hold_next = 1'b0;
          sarStart = 1'b1;
          state_next = ADCC_CONVERT;
        end
      end
      ADCC_CONVERT: begin
        // step divider gives the comparator time to settle per bit
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == STEP_LAST) begin
          cnt_next = '0;
          stepEn = sarBusy;
        end
        if (sarDone) begin
          cnt_next = '0;
          hold_next = 1'b1;
          state_next = ADCC_SAMPLE; // continuous conversion
        end
      end
    endcase
    // a new channel restarts the sample from scratch
    if (channelWrite && state_reg != ADCC_OFF) begin
      sarAbort = 1'b1;
      sarStart = 1'b0;
      cnt_next = '0;
      hold_next = 1'b1;
      state_next = ADCC_SAMPLE;
    end
    if (!converterOn) begin
      sarAbort = 1'b1;
      sarStart = 1'b0;
      hold_next = 1'b0;
      cnt_next = '0;
      state_next = ADCC_OFF;
    end
  end

  // ===========================================================
  // result bytes and done flag
  // the pair is not shadowed: a completion overwrites both bytes at once
  always_comb begin
    high_next = high_reg;
    low_next = low_reg;
    done_next = done_reg;
    if (resultHighRead) begin
      done_next = 1'b0; // low byte read leaves the flag alone
    end
    if (channelWrite) begin
      done_next = 1'b0;
    end
    // completion after the clears, so a set in the same cycle wins over a high read; a channel write blocks it
    if (sarDone && !channelWrite && converterOn) begin
      high_next = packedResult[15:8];
      low_next = packedResult[7:0];
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ADCC_OFF;
      cnt_reg <= '0;
      chan_reg <= ADCC_CHAN_RST;
      on_reg <= 1'b0;
      hold_reg <= 1'b0;
      above_reg <= 1'b0;
      below_reg <= 1'b0;
      high_reg <= ADCC_RESULT_RST;
      low_reg <= ADCC_RESULT_RST;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      chan_reg <= chan_next;
      on_reg <= on_next;
      hold_reg <= hold_next;
      above_reg <= above_next;
      below_reg <= below_next;
      high_reg <= high_next;
      low_reg <= low_next;
      done_reg <= done_next;
    end
  end

  // ===========================================================
  // bit sequencer
  adcc_sar_engine #(
    .RES_BITS(ADCC_RES_BITS)
  ) u_sar (
    .clk(clk),
    .rst(rst),
    .start(sarStart),
    .abort(sarAbort),
    .stepEn(stepEn),
    .compareHigh(compareHigh),
    .trialCode(trialCode),
    .busy(sarBusy),
    .done(sarDone),
    .result(sarResult)
  );

  // outputs, each straight from a flip-flop
  assign resultHigh = high_reg;
  assign resultLow = low_reg;
  assign conversionDoneFlag = done_reg;
  assign muxSelect = chan_reg;
  assign analogEnable = on_reg; // core powered only while on
  assign sampleHold = hold_reg;

  // low-byte read has no side effect; port kept for the bus decoder
  logic unusedLowRead;
  assign unusedLowRead = resultLowRead;
endmodule : adcc_conversion_control
`default_nettype wire

// ===== sim/adcc_core_model.sv
// adcc_core_model: behavioural analog core and 16-way input mux
// assumes: driven by the control block's mux, hold and trial pins
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
  input wire logic clk,
  input wire logic analogEnable,
  input wire logic [3:0] muxSelect,
  input wire logic sampleHold,
  input wire logic [9:0] trialCode,
  output logic compareHigh,
  output logic aboveRef,
  output logic belowRef
);
  logic [9:0] held = 10'h000;
  logic tog = 1'b0;
  // ==========
  // track and hold: follows the selected input while sampling
  always_ff @(posedge clk) begin
    tog <= ~tog;
    if (sampleHold) held <= 10'h0A5 + 10'(muxSelect) * 10'h03B;
  end
  // a core that is off answers with a changing pattern, never a level
  assign compareHigh = analogEnable ? (held >= trialCode) : tog;
  assign aboveRef = analogEnable ? (muxSelect == 4'hE) : tog;
  assign belowRef = analogEnable ? (muxSelect == 4'hF) : ~tog;
endmodule : adcc_core_model
`default_nettype wire

// ===== sim/adcc_checker.sv
// adcc_checker: port assertions of the conversion control
// assumes: bound to the top; bench samples for at least 4 cycles
`timescale 1ns/1ps
`default_nettype none
module adcc_checker
  import adcc_pkg::*;
#(parameter int SAMPLE_CYCLES = 16, parameter int STEP_CYCLES = 8) (
  input wire logic clk,
  input wire logic rst,
  input wire logic converterOn,
  input wire logic [ADCC_CHAN_BITS-1:0] channelSelectField,
  input wire logic channelWrite,
  input wire logic resultHighRead,
  input wire logic resultLowRead,
  input wire logic [7:0] resultLow,
  input wire logic conversionDoneFlag,
  input wire logic [ADCC_CHAN_BITS-1:0] muxSelect,
  input wire logic analogEnable,
  input wire logic sampleHold,
  input wire logic [ADCC_RES_BITS-1:0] trialCode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // steps of a run: sampling phase, restart after a channel change
  sequence s_sample_run;
    sampleHold [*4];
  endsequence
  sequence s_restart;
    sampleHold && !conversionDoneFlag;
  endsequence
  a_low_pad_zero: assert property (resultLow[7:2] == 6'h00)
    else $error("low byte upper bits not zero");
  a_read_clears: assert property (resultHighRead |=>
    !conversionDoneFlag || $rose(sampleHold))
    else $error("high read left flag set");
  a_low_read_keeps: assert property (resultLowRead && !resultHighRead
    && !channelWrite && conversionDoneFlag |=> conversionDoneFlag)
    else $error("low read cleared flag");
  a_chan_restart: assert property (channelWrite && converterOn |=>
    muxSelect == $past(channelSelectField) ##0 s_restart)
    else $error("channel write did not restart");
  a_start_sample: assert property ($rose(analogEnable) |-> sampleHold)
    else $error("enable without sampling");
  a_off_stops: assert property (!converterOn [*3] |->
    !sampleHold && !analogEnable)
    else $error("converter still active while off");
  a_done_next: assert property ($rose(conversionDoneFlag) |->
    $rose(sampleHold) && analogEnable)
    else $error("completion without next sample");
  a_sample_len: assert property ($rose(sampleHold) |-> s_sample_run)
    else $error("sampling phase too short");
  a_trial_msb: assert property ($fell(sampleHold) && converterOn &&
    !channelWrite |=> trialCode == 10'h200)
    else $error("first trial code wrong");
endmodule : adcc_checker
`default_nettype wire

// ===== sim/tb_adcc_conversion_control.sv
// tb_adcc_conversion_control: self-checking bench of the control block
// assumes: core model on the analog pins, short sample and step counts
`timescale 1ns/1ps
`default_nettype none
module tb_adcc_conversion_control;
  import adcc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, converterOn = 1'b0, channelWrite = 1'b0;
  logic resultHighRead = 1'b0, resultLowRead = 1'b0;
  logic compareHigh, aboveRef, belowRef, conversionDoneFlag;
  logic analogEnable, sampleHold;
  logic [3:0] channelSelectField = 4'h0, muxSelect;
  logic [7:0] resultHigh, resultLow;
  logic [9:0] trialCode;
  int nMismatch = 0, checksDone = 0;
  adcc_conversion_control #(.SAMPLE_CYCLES(4), .STEP_CYCLES(2))
    adcc_conversion_control_inst (.clk(clk), .rst(rst),
    .converterOn(converterOn), .channelSelectField(channelSelectField),
    .channelWrite(channelWrite), .resultHighRead(resultHighRead),
    .resultLowRead(resultLowRead), .compareHigh(compareHigh),
    .aboveRef(aboveRef), .belowRef(belowRef), .resultHigh(resultHigh),
    .resultLow(resultLow), .conversionDoneFlag(conversionDoneFlag),
    .muxSelect(muxSelect), .analogEnable(analogEnable),
    .sampleHold(sampleHold), .trialCode(trialCode));
  adcc_core_model adcc_core_model_inst (.clk(clk),
    .analogEnable(analogEnable), .muxSelect(muxSelect),
    .sampleHold(sampleHold), .trialCode(trialCode),
    .compareHigh(compareHigh), .aboveRef(aboveRef), .belowRef(belowRef));
  initial forever #10 clk = ~clk;
  // ==========
  // helpers
  task automatic give_verdict();
    if (nMismatch == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [9:0] s, logic [9:0] e);
    checksDone++;
    if (s !== e) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // expected code per channel, saturating on the two extreme inputs
  function automatic logic [9:0] expCode(logic [3:0] c);
    if (c == 4'hE) return 10'h3FF;
    if (c == 4'hF) return 10'h000;
    return 10'h0A5 + 10'(c) * 10'h03B;
  endfunction : expCode
  task automatic strobe(int which, logic [3:0] c);
    @(posedge clk);
    channelSelectField <= c;
    channelWrite <= (which == 0);
    resultLowRead <= (which == 1);
    resultHighRead <= (which == 2);
    @(posedge clk);
    {channelWrite, resultLowRead, resultHighRead} <= 3'h0;
    #1;
  endtask : strobe
  // bounded wait: a hang counts as a mismatch and ends the run
  task automatic waitFlag();
    int i;
    for (i = 0; i < 400 && conversionDoneFlag !== 1'b1; i++)
      @(posedge clk) #1;
    if (i == 400) begin
      chk("flag timeout", 10'h000, 10'h001);
      give_verdict();
    end
  endtask : waitFlag
  task automatic chkResult(logic [3:0] c);
    chk("code", {resultHigh, resultLow[1:0]}, expCode(c));
    chk("low pad", 10'(resultLow[7:2]), 10'h000);
  endtask : chkResult
  // ==========
  // scenarios
  task automatic tChannels();
    for (int c = 0; c < 16; c++) begin
      strobe(0, 4'(c));
      chk("flag after write", 10'(conversionDoneFlag), 10'h000);
      chk("mux", 10'(muxSelect), 10'(c));
      waitFlag();
      chkResult(4'(c));
      strobe(1, 4'(c));
      chk("flag after low", 10'(conversionDoneFlag), 10'h001);
      strobe(2, 4'(c));
      chk("flag after high", 10'(conversionDoneFlag), 10'h000);
    end
  endtask : tChannels
  task automatic tContinuous();
    waitFlag();
    chkResult(4'hF);
    strobe(2, 4'hF);
  endtask : tContinuous
  task automatic tAbort();
    strobe(0, 4'h3);
    // let a result stand so the abort has a set flag to clear
    waitFlag();
    chkResult(4'h3);
    repeat (10) @(posedge clk);
    strobe(0, 4'h9);
    chk("flag on abort", 10'(conversionDoneFlag), 10'h000);
    waitFlag();
    chkResult(4'h9);
    strobe(2, 4'h9);
  endtask : tAbort
  task automatic tOff();
    @(posedge clk);
    converterOn <= 1'b0;
    repeat (100) @(posedge clk);
    #1;
    chk("flag off", 10'(conversionDoneFlag), 10'h000);
    chk("hold off", 10'(sampleHold), 10'h000);
    chk("power off", 10'(analogEnable), 10'h000);
    @(posedge clk);
    converterOn <= 1'b1;
    waitFlag();
    chkResult(4'h9);
  endtask : tOff
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    converterOn <= 1'b1;
    tChannels();
    tContinuous();
    tAbort();
    tOff();
    give_verdict();
  end
endmodule : tb_adcc_conversion_control
bind adcc_conversion_control adcc_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES),
  .STEP_CYCLES(STEP_CYCLES)) adcc_checker_inst (.clk(clk), .rst(rst),
  .converterOn(converterOn), .channelSelectField(channelSelectField),
  .channelWrite(channelWrite), .resultHighRead(resultHighRead),
  .resultLowRead(resultLowRead), .resultLow(resultLow),
  .conversionDoneFlag(conversionDoneFlag), .muxSelect(muxSelect),
  .analogEnable(analogEnable), .sampleHold(sampleHold),
  .trialCode(trialCode));
`default_nettype wire
